// file: dv/power_stage_model.sv
// Purpose: behavioural sense comparators of the analog power stage
// Assumes: bench sets sense voltages in mV, current in uA, thermistor in 0.01% of bias
// Notes: comparators are plain levels, hysteresis is left to the supervisor
`timescale 1ns/1ps
module power_stage_model
  import fault_pkg::*;
#(
  parameter int target_mv = 1000,
  parameter int startup_trip_mv = 1050
)
(
  input wire logic [15:0] sense_pos_mv,
  input wire logic [15:0] sense_neg_mv,
  input wire logic [15:0] current_ua,
  input wire logic [15:0] therm_x100,
  input wire logic [3:0] rails_low,
  output comp_type comp_raw
);
  // ==========================================================
  // comparator levels
  logic signed [31:0] diff_mv;
  assign diff_mv = 32'(sense_pos_mv) - 32'(sense_neg_mv);
  // rail lockout levels, order vin, vcc, driver bias, internal regulator
  assign comp_raw.vin_uv = rails_low[0];
  assign comp_raw.vcc_uv = rails_low[1];
  assign comp_raw.drv_bias_uv = rails_low[2];
  assign comp_raw.ldo_uv = rails_low[3];
  assign comp_raw.ov_rise = diff_mv * 100 > target_mv * 116;
  assign comp_raw.ov_fall_n = !(diff_mv * 100 < target_mv * 100);
  assign comp_raw.startup_ov = diff_mv > startup_trip_mv;
  assign comp_raw.uv = diff_mv * 100 < target_mv * 74;
  assign comp_raw.oc_avg = current_ua > 16'h0064;
  assign comp_raw.oc_peak = current_ua > 16'h0082;
  assign comp_raw.ot_trip = therm_x100 < 16'h08b7;
  assign comp_raw.ot_clear = therm_x100 > 16'h0adb;
endmodule

// file: dv/testbench.sv
// Purpose: self-checking bench for the buck fault supervisor
// Assumes: shortened delays 20, 10 and 30 cycles, 40 MHz clock
// Notes: inputs change at the falling edge, outputs read after settling
`timescale 1ns/1ps
module testbench;
  import fault_pkg::*;
  localparam int sdly = 20;
  localparam int bdly = 10;
  localparam int hdly = 30;
  logic clk = 1'b0, rst = 1'b1, enable_pin = 1'b1, ssd = 1'b0;
  logic [7:0] cmd = 8'h80;
  logic [1:0] cfg = 2'h1;
  logic strap = 1'b0, bus_sel = 1'b0, bus_valid = 1'b0, hs_req = 1'b1, ls_req = 1'b0;
  logic [15:0] pos = 16'h03e8, neg = 16'h0000, cur = 16'h0000, therm = 16'h1388;
  logic [3:0] rails = 4'h0;
  comp_type comp_raw;
  logic hs, ls, pg;
  flags_type fl;
  int n_errors = 0, checks = 0, cycles = 0;
  // ==========================================================
  // clock, timeout and instances
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  power_stage_model u_model (.sense_pos_mv(pos), .sense_neg_mv(neg), .current_ua(cur),
    .therm_x100(therm), .rails_low(rails), .comp_raw(comp_raw));
  buck_fault_protection_manager #(.startup_delay(sdly), .blank_delay(bdly),
    .hiccup_delay(hdly)) u_dut (.clk(clk), .rst(rst), .comp_raw(comp_raw),
    .enable_pin(enable_pin), .onoff_command(cmd), .onoff_config(cfg),
    .config_strap_three(strap), .overcurrent_response_select(bus_sel),
    .bus_select_valid(bus_valid), .soft_start_done(ssd), .high_side_request(hs_req),
    .low_side_request(ls_req), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .power_good_out(pg), .fault_flags(fl));
  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic got, input logic exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: output %b, expected %b", $time, got, exp);
    end
  endtask
  // count cycles until the high-side drive reaches a level, bounded
  task automatic wait_hs(input logic lvl, output int n);
    n = 0;
    while (hs !== lvl && n < 200) begin
      cyc(1);
      n = n + 1;
    end
  endtask
  task automatic pin_toggle();
    enable_pin = 1'b0;
    cyc(6);
    enable_pin = 1'b1;
    cyc(8);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_startup();
    pos = 16'h0438; // above the start-up trip only
    cyc(8);
    check(fl.startup_ovp, 1'b0);
    cyc(sdly + 4);
    check(fl.startup_ovp, 1'b1);
    check(pg, 1'b0);
    pos = 16'h03e8;
    ssd = 1'b1;
    pin_toggle();
    check(fl.startup_ovp, 1'b0);
    check(hs, 1'b1);
    check(pg, 1'b1);
    $display("startup overvoltage test done");
  endtask
  task automatic t_rails();
    for (int i = 0; i < 4; i++) begin
      rails[i] = 1'b1;
      cyc(6);
      check(hs, 1'b0);
      check(pg, 1'b0);
      check(i == 0 ? fl.vin_uv : fl.bias_uv, 1'b1);
      rails[i] = 1'b0;
      cyc(8);
      check(hs, 1'b1);
    end
    $display("rail lockout test done");
  endtask
  task automatic t_thermal();
    ls_req = 1'b1;
    therm = 16'h07d0; // 20.00 percent trips
    cyc(6);
    check(hs, 1'b0);
    check(ls, 1'b0);
    check(fl.otp, 1'b1);
    therm = 16'h09c4; // 25.00 percent stays inside hysteresis
    cyc(8);
    check(hs, 1'b0);
    therm = 16'h0bb8;
    cyc(8);
    check(hs, 1'b1);
    ls_req = 1'b0;
    $display("over-temperature test done");
  endtask
  task automatic t_ovp();
    pos = 16'h05dc; // 150 percent at the pin, only 100 percent across the pair
    neg = 16'h01f4;
    cyc(6);
    check(hs, 1'b1);
    neg = 16'h0000;
    pos = 16'h04b0; // 120 percent
    cyc(6);
    check(pg, 1'b0);
    check(hs, 1'b0);
    check(ls, 1'b1);
    check(fl.ovp, 1'b1);
    pos = 16'h041a; // 105 percent keeps discharging
    cyc(6);
    check(ls, 1'b1);
    pos = 16'h03b6; // 95 percent releases
    cyc(6);
    check(ls, 1'b0);
    pos = 16'h04b0;
    cyc(6);
    check(ls, 1'b1);
    pos = 16'h03e8;
    cyc(6);
    check(hs, 1'b0);
    pin_toggle();
    check(hs, 1'b1);
    check(fl.ovp, 1'b0);
    $display("overvoltage test done");
  endtask
  task automatic t_uvp();
    cfg = 2'h2;
    pos = 16'h02bc; // 70 percent
    cyc(6);
    check(hs, 1'b0);
    check(pg, 1'b0);
    check(fl.uvp, 1'b1);
    pos = 16'h03e8;
    pin_toggle(); // pin is not honoured under this setting
    check(fl.uvp, 1'b1);
    cmd = 8'h00;
    cyc(6);
    cmd = 8'h80;
    cyc(8);
    check(fl.uvp, 1'b0);
    check(hs, 1'b1);
    cfg = 2'h3; // both sources honoured, command bit low turns off
    cmd = 8'h00;
    cyc(6);
    check(hs, 1'b0);
    cmd = 8'h80;
    cyc(6);
    check(hs, 1'b1);
    cfg = 2'h0; // no source honoured, pin low is ignored
    enable_pin = 1'b0;
    cyc(6);
    check(hs, 1'b1);
    enable_pin = 1'b1;
    cyc(2);
    cfg = 2'h1;
    $display("undervoltage test done");
  endtask
  task automatic t_oc_latch();
    cur = 16'h006e;
    cyc(bdly - 3);
    cur = 16'h0000;
    cyc(6);
    check(fl.ocp, 1'b0);
    check(hs, 1'b1);
    cur = 16'h0096;
    cyc(1); // shorter than the short filter
    cur = 16'h0000;
    cyc(6);
    check(fl.scp, 1'b0);
    cur = 16'h0096;
    cyc(5);
    cur = 16'h0000;
    cyc(5);
    check(fl.scp, 1'b1);
    check(hs, 1'b0);
    pin_toggle();
    cur = 16'h006e;
    cyc(bdly + 8);
    check(fl.ocp, 1'b1);
    cur = 16'h0000;
    cyc(20);
    check(hs, 1'b0);
    pin_toggle();
    check(hs, 1'b1);
    $display("overcurrent latch test done");
  endtask
  task automatic t_retry();
    int n;
    bus_valid = 1'b1;
    bus_sel = 1'b1; // bus bit outranks the strap
    cur = 16'h006e;
    wait_hs(1'b0, n);
    check(n <= bdly + 6, 1'b1);
    wait_hs(1'b1, n);
    check(n >= hdly, 1'b1);
    check(n <= hdly + 10, 1'b1);
    wait_hs(1'b0, n);
    check(n <= bdly + 6, 1'b1);
    cur = 16'h0000;
    wait_hs(1'b1, n);
    cyc(hdly + 10);
    check(hs, 1'b1);
    check(pg, 1'b1);
    strap = 1'b1; // bus bit low outranks the retry strap
    bus_sel = 1'b0;
    cur = 16'h006e;
    cyc(bdly + 8);
    cur = 16'h0000;
    cyc(hdly + 10);
    check(hs, 1'b0);
    check(fl.ocp, 1'b1);
    pin_toggle();
    bus_valid = 1'b0; // strap alone now selects retry
    cur = 16'h006e;
    wait_hs(1'b0, n);
    wait_hs(1'b1, n);
    cur = 16'h0000;
    check(n <= hdly + 10, 1'b1);
    cyc(hdly + 10);
    check(hs, 1'b1);
    $display("hiccup retry test done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    cyc(8);
    rst = 1'b0;
    cyc(2);
    t_startup();
    t_rails();
    t_thermal();
    t_ovp();
    t_uvp();
    t_oc_latch();
    t_retry();
    wrap_up();
  end
endmodule

// file: inc/fault_pkg.sv
// Purpose: shared constants and types for the buck fault supervisor
// Assumes: 40 MHz clock, comparator results arrive as digital levels
// Notes: times kept in their own unit, cycle counts derived from the clock rate
package fault_pkg;
  localparam int clk_mhz = 40;
  localparam int clk_period_ns = 25;
  // start-up overvoltage arming delay, typical and worst case
  localparam int startup_ovp_us = 5500;
  localparam int startup_ovp_worst_us = 6500;
  localparam int startup_ovp_cycles = startup_ovp_us * clk_mhz;
  // average overcurrent blanking
  localparam int ocp_blank_us = 128;
  localparam int ocp_blank_cycles = ocp_blank_us * clk_mhz;
  // short-circuit filter, longest time rounds down, at least one cycle
  localparam int scp_filter_ns = 50;
  localparam int scp_filter_raw = scp_filter_ns / clk_period_ns;
  localparam int scp_filter_cycles = (scp_filter_raw < 1) ? 1 : scp_filter_raw;
  // hiccup off time in retry mode
  localparam int hiccup_us = 9000;
  localparam int hiccup_cycles = hiccup_us * clk_mhz;
  localparam int cnt_width = 24;
  localparam int scp_width = 4;
  // on/off command byte: bit 7 is the on request
  localparam int onoff_on_bit = 7;
  // on/off configuration: which sources may turn on and clear latches
  localparam logic [1:0] onoff_use_pin = 2'h1;
  localparam logic [1:0] onoff_use_cmd = 2'h2;
  // overcurrent response select values
  localparam logic ocp_resp_latch = 1'h0;
  localparam logic ocp_resp_retry = 1'h1;
  localparam int num_flags = 8;

  // comparator results from the analog side, each high when tripped except ov_fall_n, which is low
  typedef struct packed {
    logic vin_uv;        // input below its lockout level
    logic vcc_uv;        // bias rail below lockout
    logic drv_bias_uv;   // driver bias rail below lockout
    logic ldo_uv;        // internal regulator rail below lockout
    logic ov_rise;       // sense+ minus sense- above 116% level
    logic ov_fall_n;     // low when difference is below 100% level
    logic startup_ov;    // difference above the boot-level start-up trip
    logic uv;            // output below 74% of reference
    logic oc_avg;        // sensed current above 100 uA equivalent
    logic oc_peak;       // instantaneous current above 130% of average level
    logic ot_trip;       // thermistor below 22.31% of bias
    logic ot_clear;      // thermistor above 27.79% of bias
  } comp_type;

  // status flags, one per fault type
  typedef struct packed {
    logic vin_uv;
    logic bias_uv;
    logic ovp;
    logic startup_ovp;
    logic uvp;
    logic ocp;
    logic scp;
    logic otp;
  } flags_type;

  typedef enum logic [1:0] {
    st_off     = 2'h0,
    st_run     = 2'h1,
    st_latched = 2'h2,
    st_hiccup  = 2'h3
  } state_type;
endpackage

// file: src/buck_fault_protection_manager.sv
// Purpose: fault supervision, shutdown, latch-off and hiccup for a buck controller
// Assumes: comparators digitised upstream, rst is the power-on reset of the bias supply
// Notes: gate requests come from the modulator and are gated here
`timescale 1ns/1ps
module buck_fault_protection_manager
  import fault_pkg::*;
#(
  parameter int startup_delay = startup_ovp_cycles,
  parameter int blank_delay = ocp_blank_cycles,
  parameter int hiccup_delay = hiccup_cycles
)
(
  input wire logic clk,
  input wire logic rst,
  input wire comp_type comp_raw,
  input wire logic enable_pin,
  input wire logic [7:0] onoff_command,
  input wire logic [1:0] onoff_config,
  input wire logic config_strap_three,
  input wire logic overcurrent_response_select,
  input wire logic bus_select_valid,
  input wire logic soft_start_done,
  input wire logic high_side_request,
  input wire logic low_side_request,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic power_good_out,
  output flags_type fault_flags
);
  comp_type comp;
  state_type state;
  state_type next_state;
  logic [cnt_width-1:0] start_cnt;
  logic [cnt_width-1:0] blank_cnt;
  logic [cnt_width-1:0] hic_cnt;
  logic [scp_width-1:0] scp_cnt;
  logic ot_active;
  logic ov_active;
  logic startup_armed;
  logic enable_q;
  logic cmd_q;
  logic toggle_armed;
  logic flag_ovp, flag_sovp, flag_uvp, flag_ocp, flag_scp;
  flags_type next_flags;

  // =============================================
  // input synchronisers
  sync_filter u_sync (
    .clk(clk),
    .rst(rst),
    .raw(comp_raw),
    .synced(comp)
  );

  // =============================================
  // enable sources and clear events
  wire pin_on = (onoff_config & onoff_use_pin) == 2'h0 || enable_pin;
  wire cmd_on = (onoff_config & onoff_use_cmd) == 2'h0 || onoff_command[onoff_on_bit];
  wire enabled = pin_on && cmd_on;
  // toggles only count once the edge history holds a real sample, no false edge after reset
  wire pin_toggle = toggle_armed && (onoff_config & onoff_use_pin) != 2'h0 &&
                    (enable_pin != enable_q);
  wire cmd_toggle = toggle_armed && (onoff_config & onoff_use_cmd) != 2'h0 &&
                    (onoff_command[onoff_on_bit] != cmd_q);
  wire latch_clear = pin_toggle || cmd_toggle;
  wire bias_uv = comp.vcc_uv || comp.drv_bias_uv || comp.ldo_uv;
  wire rails_ok = !bias_uv && !comp.vin_uv;
  wire retry_mode = (bus_select_valid ? overcurrent_response_select : config_strap_three)
                    == ocp_resp_retry;

  // =============================================
  // fault detections
  wire ocp_hit = (blank_cnt == cnt_width'(blank_delay));
  wire scp_hit = (scp_cnt == scp_width'(scp_filter_cycles)) && comp.oc_peak;
  wire ovp_hit = comp.ov_rise;
  wire sovp_hit = startup_armed && !soft_start_done && comp.startup_ov;
  wire uvp_hit = comp.uv && soft_start_done;
  wire oc_any = ocp_hit || scp_hit;
  wire latch_fault = ovp_hit || sovp_hit || uvp_hit || (oc_any && !retry_mode);

  // over-temperature hysteresis and ov low-side hysteresis
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ot_active <= 1'h0;
      ov_active <= 1'h0;
    end else begin
      if (comp.ot_trip) ot_active <= 1'h1;
      else if (comp.ot_clear) ot_active <= 1'h0;
      if (comp.ov_rise) ov_active <= 1'h1;
      else if (!comp.ov_fall_n) ov_active <= 1'h0;
    end
  end

  // =============================================
  // delay counters on the internal clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_cnt <= '0;
      startup_armed <= 1'h0;
      blank_cnt <= '0;
      scp_cnt <= '0;
    end else begin
      // start-up check arms after rails stay good for the delay
      if (!rails_ok) begin
        start_cnt <= '0;
        startup_armed <= 1'h0;
      end else if (start_cnt == cnt_width'(startup_delay)) begin
        startup_armed <= 1'h1;
      end else begin
        start_cnt <= start_cnt + 1'b1;
      end
      // continuous excess needed through the blanking window
      if (!comp.oc_avg || state != st_run) blank_cnt <= '0;
      else if (blank_cnt != cnt_width'(blank_delay)) blank_cnt <= blank_cnt + 1'b1;
      if (!comp.oc_peak || state != st_run) scp_cnt <= '0;
      else if (scp_cnt != scp_width'(scp_filter_cycles)) scp_cnt <= scp_cnt + 1'b1;
    end
  end

  // =============================================
  // next state
  always_comb begin
    next_state = state;
    case (state)
      st_off: begin
        if (enabled && rails_ok && !ot_active) next_state = st_run;
      end
      st_run: begin
        if (latch_fault) next_state = st_latched;
        else if (oc_any) next_state = st_hiccup;
        else if (!enabled || !rails_ok || ot_active) next_state = st_off;
      end
      st_latched: begin
        if (latch_clear) next_state = st_off;
      end
      st_hiccup: begin
        if (!enabled || !rails_ok) next_state = st_off;
        else if (hic_cnt == cnt_width'(hiccup_delay)) next_state = st_off;
      end
      default: next_state = st_off;
    endcase
  end

  // state and hiccup timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_off;
      hic_cnt <= '0;
      enable_q <= 1'h0;
      cmd_q <= 1'h0;
      toggle_armed <= 1'h0;
    end else begin
      state <= next_state;
      toggle_armed <= 1'h1;
      enable_q <= enable_pin;
      cmd_q <= onoff_command[onoff_on_bit];
      if (state == st_hiccup) hic_cnt <= hic_cnt + 1'b1;
      else hic_cnt <= '0;
    end
  end

  // =============================================
  // status flags: latch sticky until cleared, set wins over clear
  always_comb begin
    next_flags.vin_uv = comp.vin_uv;
    next_flags.bias_uv = bias_uv;
    next_flags.otp = ot_active;
    next_flags.ovp = ovp_hit || (flag_ovp && !latch_clear);
    next_flags.startup_ovp = sovp_hit || (flag_sovp && !latch_clear);
    next_flags.uvp = (state == st_run && uvp_hit) || (flag_uvp && !latch_clear);
    next_flags.ocp = (state == st_run && ocp_hit) || (flag_ocp && !latch_clear && state != st_off);
    next_flags.scp = (state == st_run && scp_hit) || (flag_scp && !latch_clear && state != st_off);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_flags <= '0;
      flag_ovp <= 1'h0;
      flag_sovp <= 1'h0;
      flag_uvp <= 1'h0;
      flag_ocp <= 1'h0;
      flag_scp <= 1'h0;
    end else begin
      fault_flags <= next_flags;
      flag_ovp <= next_flags.ovp;
      flag_sovp <= next_flags.startup_ovp;
      flag_uvp <= next_flags.uvp;
      flag_ocp <= next_flags.ocp;
      flag_scp <= next_flags.scp;
    end
  end

  // =============================================
  // gate and power-good outputs
  wire ov_latched = state == st_latched && (flag_ovp || flag_sovp);
  wire next_hs = state == st_run && !ot_active && high_side_request;
  wire next_ls = ov_latched ? (ov_active && !ot_active)
                 : (state == st_run && !ot_active && low_side_request);
  wire next_pg = state == st_run && soft_start_done && rails_ok && !ot_active &&
                 !oc_any && !ov_active;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_side_gate_drive <= 1'h0;
      low_side_gate_drive <= 1'h0;
      power_good_out <= 1'h0;
    end else begin
      high_side_gate_drive <= next_hs;
      low_side_gate_drive <= next_ls;
      power_good_out <= next_pg;
    end
  end

  // =============================================
  // checks
  a_ot_gates_low: assert property (@(posedge clk) disable iff (rst)
    ot_active |=> !high_side_gate_drive && !low_side_gate_drive)
    else $error("gates on during over-temperature");
  a_latch_pg_low: assert property (@(posedge clk) disable iff (rst)
    state == st_latched |=> !power_good_out)
    else $error("power good high while latched");
  a_latch_hold: assert property (@(posedge clk) disable iff (rst)
    state == st_latched && !latch_clear |=> state == st_latched)
    else $error("latch released without clear");
  a_ov_to_latch: assert property (@(posedge clk) disable iff (rst)
    state == st_run && comp.ov_rise |=> state == st_latched)
    else $error("overvoltage did not latch");
  a_ov_ls_on: assert property (@(posedge clk) disable iff (rst)
    ov_latched && comp.ov_rise && !ot_active && !comp.ot_trip && !latch_clear
    |=> ##1 low_side_gate_drive)
    else $error("low side not discharging");
  // undervoltage response: latch first, both gates low from the next edge
  sequence s_uv_latched;
    state == st_latched ##1 !high_side_gate_drive && !low_side_gate_drive;
  endsequence
  a_uv_latch: assert property (@(posedge clk) disable iff (rst)
    state == st_run && uvp_hit |=> s_uv_latched)
    else $error("undervoltage not latched");
  a_blank_short: assert property (@(posedge clk) disable iff (rst)
    $rose(blank_cnt != '0) |-> !ocp_hit [*2])
    else $error("overcurrent declared before blanking");
  a_retry_hiccup: assert property (@(posedge clk) disable iff (rst)
    state == st_run && oc_any && retry_mode && !latch_fault |=> state == st_hiccup)
    else $error("retry mode did not hiccup");
  a_bias_off: assert property (@(posedge clk) disable iff (rst)
    state == st_run && bias_uv && !latch_fault && !oc_any |=> state == st_off)
    else $error("bias undervoltage did not stop");
  a_pg_fault: assert property (@(posedge clk) disable iff (rst)
    (bias_uv || ot_active) |=> !power_good_out)
    else $error("power good high during fault");
endmodule

// file: src/sync_filter.sv
// Purpose: two-flop synchroniser per comparator bit
// Assumes: single clock domain, asynchronous active-high reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module sync_filter
  import fault_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire comp_type raw,
  output comp_type synced
);
  localparam int width = $bits(comp_type);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;

  // =============================================
  // per-bit double flop
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1[i] <= 1'h0;
          stage2[i] <= 1'h0;
        end else begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign synced = comp_type'(stage2);
endmodule
